/* File: design/pcad_decoder.sv */
// board address decoder: memory, i/o and interrupt routing
// What this block does
// - dram takes byte, word, longword accesses
// - dram reachable from cpu and bridge
// - both firmwares in one 256k by 8 flash
// - system firmware shadowed; video shadow optional
// - unused 3.9g region maps bridge windows
// - 63m extended region sharable with bridge
// - mezzanine firmware may map into extended
// - 64k i/o space, all access widths
// - peripherals decode below port 0x400
// - interrupt controllers at 020 and 0a0
// - timer at four ports from 040
// - clock at 070 and 071, nmi passed unmasked
// - first serial port at seven ports 3f8
// - lpt2, com3, com4 ranges unimplemented
// - 256 vectors at 00000 to 003ff
// - sixteen maskable requests plus nmi
// - cascade on master 2, nine replaces two
`default_nettype none
module pcad_decoder
    import pcad_pkg::*;
#(
    parameter int  DRAM_BYTES = 32'h0400_0000
)
(
    // clock and reset
    input  wire logic                  core_clk,
    input  wire logic                  srst,
    // processor cycle
    input  wire pcad_pkg::pcad_req_s   cpu_req,
    output logic                       cpu_ready,
    // bridge slave cycle into dram
    input  wire pcad_pkg::pcad_req_s   vme_req,
    output logic                       vme_ready,
    // shadow and mezzanine options
    input  wire logic                  video_shadow_en,
    input  wire logic                  shared_en,
    input  wire logic                  mezz_fitted,
    input  wire logic [31:0]           mezz_rom_base,
    input  wire logic [31:0]           mezz_rom_size,
    // decoded selection
    output pcad_pkg::pcad_sel_s        sel,
    output logic                       shadow_hit,
    output logic                       mezz_rom_hit,
    // interrupt requests
    input  wire logic [15:0]           irq_in,
    input  wire logic                  nmi_in,
    output logic [7:0]                 master_req,
    output logic [7:0]                 slave_req,
    output logic                       nmi_out,
    output logic [7:0]                 vector_index,
    output logic [9:0]                 vector_addr
);
    import pcad_pkg::*;

    // ***********************************
    // state
    // ***********************************
    typedef struct packed {
        pcad_sel_s   sel;
        logic        shadow;
        logic        mezz;
        logic        grant_vme;
        logic [7:0]  mreq;
        logic [7:0]  sreq;
        logic        nmi;
        logic [7:0]  vidx;
    } pcad_state_s;

    pcad_state_s state_ff;
    pcad_state_s nxt_state;

    pcad_req_s   req;
    logic        use_vme;
    logic [31:0] a;
    logic [15:0] port;
    pcad_tgt_e   tgt;
    logic [31:0] offs;
    logic        shd;
    logic        mz;
    logic [3:0]  irq_num;

    // ***********************************
    // source arbitration
    // ***********************************
    always_comb
    begin
        // bridge wins when cpu idle, or on alternate turns
        use_vme = vme_req.valid && (!cpu_req.valid || state_ff.grant_vme);
        req     = use_vme ? vme_req : cpu_req;
    end

    assign cpu_ready = cpu_req.valid && !use_vme;
    assign vme_ready = use_vme;

    // ***********************************
    // decode
    // ***********************************
    always_comb
    begin
        a    = req.addr;
        port = req.addr[15:0];
        tgt  = TGT_NONE;
        offs = 32'h0;
        shd  = 1'b0;
        mz   = 1'b0;
        if (use_vme)
        begin
            // bridge slave only reaches dram
            if (!req.io && a < DRAM_BYTES)
            begin
                tgt  = TGT_DRAM;
                offs = a;
            end
        end
        else if (req.io)
        begin
            if (port <= IO_STD_HI)
            begin
                if (port >= IO_PIC_M_LO && port <= IO_PIC_M_HI)
                begin
                    tgt  = TGT_PIC_M;
                    offs = {16'h0, port - IO_PIC_M_LO};
                end
                else if (port >= IO_PIC_S_LO && port <= IO_PIC_S_HI)
                begin
                    tgt  = TGT_PIC_S;
                    offs = {16'h0, port - IO_PIC_S_LO};
                end
                else if (port >= IO_PIT_LO && port <= IO_PIT_HI)
                begin
                    tgt  = TGT_PIT;
                    offs = {16'h0, port - IO_PIT_LO};
                end
                else if (port >= IO_RTC_LO && port <= IO_RTC_HI)
                begin
                    tgt  = TGT_RTC;
                    offs = {16'h0, port - IO_RTC_LO};
                end
                else if (port >= IO_SER1_LO && port <= IO_SER1_HI)
                begin
                    tgt  = TGT_SER1;
                    offs = {16'h0, port - IO_SER1_LO};
                end
                else if ((port >= IO_LPT2_LO && port <= IO_LPT2_HI)
                      || (port >= IO_SER4_LO && port <= IO_SER4_HI)
                      || (port >= IO_SER3_LO && port <= IO_SER3_HI))
                begin
                    tgt = TGT_NONE;
                end
                else
                begin
                    tgt = TGT_NONE;
                end
            end
            else
            begin
                // free range above standard peripherals
                tgt  = TGT_IO_OTHER;
                offs = {16'h0, port};
            end
        end
        else
        begin
            if (a <= MEM_USER_HI)
            begin
                // vector table lives in low dram
                tgt  = (a < DRAM_BYTES) ? TGT_DRAM : TGT_NONE;
                offs = a;
            end
            else if (a >= MEM_VRAM_LO && a <= MEM_VRAM_HI)
            begin
                tgt  = TGT_VRAM;
                offs = a - MEM_VRAM_LO;
            end
            else if (a >= MEM_VROM_LO && a <= MEM_VROM_HI)
            begin
                shd  = video_shadow_en;
                tgt  = video_shadow_en ? TGT_DRAM : TGT_VROM;
                offs = video_shadow_en ? a : a - MEM_VROM_LO;
            end
            else if (a >= MEM_SCSI_LO && a <= MEM_SCSI_HI)
            begin
                tgt  = TGT_SCSI;
                offs = a - MEM_SCSI_LO;
            end
            else if (a >= MEM_SYSROM_LO && a <= MEM_SYSROM_HI)
            begin
                // reads hit the shadow copy; writes load it
                shd  = 1'b1;
                tgt  = TGT_DRAM;
                offs = a;
            end
            else if (a >= MEM_EXT_LO && a <= MEM_EXT_HI)
            begin
                if (mezz_fitted && a >= mezz_rom_base
                    && a - mezz_rom_base < mezz_rom_size)
                begin
                    mz   = 1'b1;
                    tgt  = TGT_IO_OTHER;
                    offs = a - mezz_rom_base;
                end
                else if (a < DRAM_BYTES)
                begin
                    tgt  = shared_en ? TGT_SHARED : TGT_DRAM;
                    offs = a;
                end
            end
            else if (a >= MEM_WIN_LO && a <= MEM_WIN_HI)
            begin
                tgt  = TGT_VME_WIN;
                offs = a - MEM_WIN_LO;
            end
            else if (a >= MEM_TOPROM_LO)
            begin
                tgt  = TGT_TOPROM;
                offs = a - MEM_TOPROM_LO;
            end
        end
    end

    // ***********************************
    // next state: selection, arbitration turn and interrupt routing
    // ***********************************
    always_comb
    begin
        nxt_state            = state_ff;
        nxt_state.grant_vme  = use_vme ? 1'b0 : (vme_req.valid ? 1'b1 : state_ff.grant_vme);
        nxt_state.sel.valid  = req.valid && (tgt != TGT_NONE);
        nxt_state.sel.tgt    = req.valid ? tgt : TGT_NONE;
        nxt_state.sel.offset = offs;
        nxt_state.sel.be     = req.be;
        nxt_state.sel.write  = req.write && req.valid && (tgt != TGT_NONE);
        nxt_state.sel.vme_src    = use_vme;
        // flash holds both images in one 256k array
        nxt_state.sel.flash_addr = offs[FLASH_AW-1:0];
        nxt_state.shadow     = shd && req.valid;
        nxt_state.mezz       = mz && req.valid;
        // master 2 carries the slave cascade
        nxt_state.mreq       = irq_in[7:0];
        nxt_state.mreq[CASCADE_IN] = |state_ff.sreq;
        nxt_state.sreq       = irq_in[15:8];
        // legacy line two joins line nine on slave input one
        nxt_state.sreq[SLAVE_NINE - SLAVE_BASE] = irq_in[SLAVE_NINE] | irq_in[CASCADE_IN];
        nxt_state.nmi        = nmi_in;
        irq_num = 4'h0;
        for (int i = IRQ_LINES - 1; i >= 0; i--)
        begin
            if (irq_in[i] && i != CASCADE_IN)
            begin
                irq_num = 4'(i);
            end
        end
        nxt_state.vidx = (irq_num < 4'(SLAVE_BASE)) ? VEC_BASE_M + {4'h0, irq_num}
                                                    : VEC_BASE_S + {4'h0, irq_num};
        if (srst)
        begin
            nxt_state = '0;
        end
    end

    always_ff @(posedge core_clk)
    begin
        state_ff <= nxt_state;
    end

    // ***********************************
    // outputs
    // ***********************************
    assign sel          = state_ff.sel;
    assign shadow_hit   = state_ff.shadow;
    assign mezz_rom_hit = state_ff.mezz;
    assign master_req   = state_ff.mreq;
    assign slave_req    = state_ff.sreq;
    assign nmi_out      = state_ff.nmi;
    assign vector_index = state_ff.vidx;
    // each vector is four bytes inside the low table
    assign vector_addr  = {state_ff.vidx, 2'b00};
endmodule : pcad_decoder
`default_nettype wire

/* File: design/pcad_pkg.sv */
// package: address map, target codes and carrier structs for the board address decoder
`default_nettype none
package pcad_pkg;
    // ***********************************
    // memory map
    // ***********************************
    localparam logic [31:0] MEM_IVT_LO     = 32'h0000_0000;
    localparam logic [31:0] MEM_IVT_HI     = 32'h0000_03ff;
    localparam int          IVT_ENTRIES    = 256;
    localparam logic [31:0] MEM_USER_HI    = 32'h0009_ffff;
    localparam logic [31:0] MEM_VRAM_LO    = 32'h000a_0000;
    localparam logic [31:0] MEM_VRAM_HI    = 32'h000b_ffff;
    localparam logic [31:0] MEM_VROM_LO    = 32'h000c_0000;
    localparam logic [31:0] MEM_VROM_HI    = 32'h000c_7fff;
    localparam logic [31:0] MEM_SCSI_LO    = 32'h000c_8000;
    localparam logic [31:0] MEM_SCSI_HI    = 32'h000c_ffff;
    localparam logic [31:0] MEM_SYSROM_LO  = 32'h000e_0000;
    localparam logic [31:0] MEM_SYSROM_HI  = 32'h000f_ffff;
    localparam logic [31:0] MEM_EXT_LO     = 32'h0010_0000;
    localparam logic [31:0] MEM_EXT_HI     = 32'h03ff_ffff;
    localparam logic [31:0] MEM_WIN_LO     = 32'h0400_0000;
    localparam logic [31:0] MEM_WIN_HI     = 32'hfffe_ffff;
    localparam logic [31:0] MEM_TOPROM_LO  = 32'hffff_0000;
    localparam int          FLASH_AW       = 18;
    // ***********************************
    // i/o map
    // ***********************************
    localparam logic [15:0] IO_STD_HI      = 16'h03ff;
    localparam logic [15:0] IO_PIC_M_LO    = 16'h0020;
    localparam logic [15:0] IO_PIC_M_HI    = 16'h0021;
    localparam logic [15:0] IO_PIT_LO      = 16'h0040;
    localparam logic [15:0] IO_PIT_HI      = 16'h0043;
    localparam logic [15:0] IO_RTC_LO      = 16'h0070;
    localparam logic [15:0] IO_RTC_HI      = 16'h0071;
    localparam logic [15:0] IO_PIC_S_LO    = 16'h00a0;
    localparam logic [15:0] IO_PIC_S_HI    = 16'h00a1;
    localparam logic [15:0] IO_SER1_LO     = 16'h03f8;
    localparam logic [15:0] IO_SER1_HI     = 16'h03fe;
    localparam logic [15:0] IO_LPT2_LO     = 16'h0278;
    localparam logic [15:0] IO_LPT2_HI     = 16'h027f;
    localparam logic [15:0] IO_SER4_LO     = 16'h02e8;
    localparam logic [15:0] IO_SER4_HI     = 16'h02ee;
    localparam logic [15:0] IO_SER3_LO     = 16'h03e8;
    localparam logic [15:0] IO_SER3_HI     = 16'h03ee;
    // ***********************************
    // interrupt numbering
    // ***********************************
    localparam int          IRQ_LINES      = 16;
    localparam int          CASCADE_IN     = 2;
    localparam int          SLAVE_NINE     = 9;
    localparam int          SLAVE_BASE     = 8;
    localparam logic [7:0]  VEC_BASE_M     = 8'h08;
    localparam logic [7:0]  VEC_BASE_S     = 8'h68;
    // ***********************************
    // targets and carriers
    // ***********************************
    typedef enum logic [3:0] {
        TGT_NONE, TGT_DRAM, TGT_VRAM, TGT_VROM, TGT_SCSI, TGT_SYSROM, TGT_SHARED,
        TGT_VME_WIN, TGT_TOPROM, TGT_PIC_M, TGT_PIC_S, TGT_PIT, TGT_RTC, TGT_SER1,
        TGT_IO_OTHER
    } pcad_tgt_e;

    typedef struct packed {
        logic        valid;
        logic        io;
        logic [31:0] addr;
        logic [3:0]  be;
        logic        write;
    } pcad_req_s;

    typedef struct packed {
        logic                valid;
        pcad_tgt_e           tgt;
        logic [31:0]         offset;
        logic [3:0]          be;
        logic                write;
        logic                vme_src;
        logic [FLASH_AW-1:0] flash_addr;
    } pcad_sel_s;
endpackage : pcad_pkg
`default_nettype wire

/* File: tb/pcad_bus_model.sv */
// partner model: local processor and bridge master issuing cycles
`default_nettype none
module pcad_bus_model
    import pcad_pkg::*;
(
    // clock
    input  wire logic                core_clk,
    // cycles toward the decoder
    output var  pcad_pkg::pcad_req_s cpu_req,
    input  wire logic                cpu_ready,
    output var  pcad_pkg::pcad_req_s vme_req,
    input  wire logic                vme_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        cpu_req = '0;
        vme_req = '0;
    end
    // hold the cycle until taken or eight cycles pass, then release with a scrambled address
    task automatic cyc(input bit vme, input pcad_req_s r, output bit ok);
        ok = 1'b0;
        if (r.io)
            r.addr[31:16] = 16'h0000;
        @(posedge core_clk);
        #1;
        if (vme)
            vme_req = r;
        else
            cpu_req = r;
        for (int i = 0; i < 8 && !ok; i++)
        begin
            @(negedge core_clk);
            ok = vme ? vme_ready : cpu_ready;
            @(posedge core_clk);
        end
        #1;
        r.valid = 1'b0;
        r.addr  = ~r.addr;
        if (vme)
            vme_req = r;
        else
            cpu_req = r;
    endtask : cyc
endmodule : pcad_bus_model
`default_nettype wire

/* File: tb/pcad_decoder_assertions.sv */
// checker: port-level relations of the board address decoder
`default_nettype none
module pcad_decoder_assertions
    import pcad_pkg::*;
#(
    parameter int DRAM_BYTES = 32'h0400_0000
)
(
    // clock and reset
    input wire logic                core_clk,
    input wire logic                srst,
    // watched ports
    input wire pcad_pkg::pcad_req_s cpu_req,
    input wire logic                cpu_ready,
    input wire pcad_pkg::pcad_sel_s sel,
    input wire logic [15:0]         irq_in,
    input wire logic                nmi_in,
    input wire logic [7:0]          master_req,
    input wire logic [7:0]          slave_req,
    input wire logic                nmi_out,
    input wire logic [7:0]          vector_index,
    input wire logic [9:0]          vector_addr
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);
    logic        io_tk;
    logic [15:0] pt;
    assign io_tk = cpu_req.valid && cpu_ready && cpu_req.io;
    assign pt    = cpu_req.addr[15:0];
    sequence s_nine_seen;
        irq_in[9] ##1 slave_req[1];
    endsequence
    a_serial_port: assert property (
        io_tk && pt >= 16'h03f8 && pt <= 16'h03fe |=> sel.valid && sel.tgt == TGT_SER1)
        else $error("serial port cycle not routed");
    a_reserved_quiet: assert property (
        io_tk && pt inside {[16'h0278:16'h027f], [16'h02e8:16'h02ee],
        [16'h03e8:16'h03ee], 16'h0044} |=> !sel.valid && !sel.write)
        else $error("reserved port selected a target");
    a_master_ctrl: assert property (
        io_tk && pt[15:1] == 15'h0010 |=> sel.tgt == TGT_PIC_M)
        else $error("master controller not selected");
    a_timer_ports: assert property (
        io_tk && pt[15:2] == 14'h0010 |=> sel.tgt == TGT_PIT)
        else $error("timer not selected");
    a_rtc_ports: assert property (
        io_tk && pt[15:1] == 15'h0038 |=> sel.tgt == TGT_RTC)
        else $error("clock port not selected");
    a_be_pass: assert property (
        cpu_req.valid && cpu_ready |=> !sel.valid || sel.be == $past(cpu_req.be))
        else $error("byte enables altered");
    a_nmi_follow: assert property (
        !$past(srst) |-> nmi_out == $past(nmi_in))
        else $error("nmi not passed after one cycle");
    a_vec_scale: assert property (
        irq_in == 16'h0001 |=> vector_addr == {8'h08, 2'b00})
        else $error("vector address not index times four");
    a_nine_slave: assert property (
        irq_in[9] || irq_in[2] |=> slave_req[1])
        else $error("request nine not on slave input one");
    a_cascade_chain: assert property (
        s_nine_seen |=> master_req[2])
        else $error("slave request not cascaded to master two");
endmodule : pcad_decoder_assertions
bind pcad_decoder pcad_decoder_assertions #(.DRAM_BYTES(DRAM_BYTES)) pcad_decoder_assertions_i (
    .core_clk(core_clk), .srst(srst), .cpu_req(cpu_req), .cpu_ready(cpu_ready), .sel(sel),
    .irq_in(irq_in), .nmi_in(nmi_in), .master_req(master_req), .slave_req(slave_req),
    .nmi_out(nmi_out), .vector_index(vector_index), .vector_addr(vector_addr));
`default_nettype wire

/* File: tb/tb_pcad_decoder.sv */
// testbench for the board address decoder
`default_nettype none
module tb_pcad_decoder;
    import pcad_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic io; logic [31:0] a; pcad_tgt_e t;} pcad_row_s;
    localparam pcad_row_s ROWS [0:18] = '{
        '{1, 32'h20, TGT_PIC_M}, '{1, 32'h21, TGT_PIC_M}, '{1, 32'ha1, TGT_PIC_S},
        '{1, 32'h43, TGT_PIT}, '{1, 32'h44, TGT_NONE}, '{1, 32'h70, TGT_RTC},
        '{1, 32'h71, TGT_RTC}, '{1, 32'h3f8, TGT_SER1}, '{1, 32'h3fe, TGT_SER1},
        '{1, 32'h3ff, TGT_NONE}, '{1, 32'h278, TGT_NONE}, '{1, 32'h2ee, TGT_NONE},
        '{1, 32'h3e8, TGT_NONE}, '{1, 32'h400, TGT_IO_OTHER}, '{0, 32'h3fc, TGT_DRAM},
        '{0, 32'ha0000, TGT_VRAM}, '{0, 32'hc0000, TGT_VROM},
        '{0, 32'h4000000, TGT_VME_WIN}, '{0, 32'hffff0000, TGT_TOPROM}};
    localparam logic [3:0] BES [0:2] = '{4'h1, 4'h3, 4'hf};
    localparam int IRQS [0:2] = '{0, 9, 15};
    localparam logic [7:0] VECS [0:2] = '{8'h08, 8'h71, 8'h77};
    logic              core_clk, srst, video_shadow_en, shared_en, mezz_fitted, nmi_in;
    logic [31:0]       mezz_rom_base, mezz_rom_size;
    logic [15:0]       irq_in;
    pcad_req_s         cpu_req, vme_req;
    logic              cpu_ready, vme_ready, shadow_hit, mezz_rom_hit, nmi_out;
    pcad_sel_s         sel;
    logic [7:0]        master_req, slave_req, vector_index, exp_v;
    logic [9:0]        vector_addr;
    int                err_total, tests_run;
    bit                ok, ok2, wr;
    pcad_bus_model bus_i (.core_clk(core_clk), .cpu_req(cpu_req), .cpu_ready(cpu_ready),
        .vme_req(vme_req), .vme_ready(vme_ready));
    pcad_decoder pcad_decoder_i (.core_clk(core_clk), .srst(srst), .cpu_req(cpu_req),
        .cpu_ready(cpu_ready), .vme_req(vme_req), .vme_ready(vme_ready),
        .video_shadow_en(video_shadow_en), .shared_en(shared_en), .mezz_fitted(mezz_fitted),
        .mezz_rom_base(mezz_rom_base), .mezz_rom_size(mezz_rom_size), .sel(sel),
        .shadow_hit(shadow_hit), .mezz_rom_hit(mezz_rom_hit), .irq_in(irq_in),
        .nmi_in(nmi_in), .master_req(master_req), .slave_req(slave_req),
        .nmi_out(nmi_out), .vector_index(vector_index), .vector_addr(vector_addr));
    initial
    begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic end_sim();
        $display("compares %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : end_sim
    task automatic go(input bit vme, input bit io, input logic [31:0] a, input logic [3:0] be);
        bus_i.cyc(vme, '{1'b1, io, a, be, wr}, ok);
        if (!ok)
        begin
            err_total++;
            end_sim();
        end
    endtask : go
    initial
    begin
        {srst, video_shadow_en, shared_en, mezz_fitted, nmi_in} = 5'h10;
        {mezz_rom_base, mezz_rom_size, irq_in} = '0;
        repeat (20) @(posedge core_clk);
        #1;
        chk(sel.valid, 1'b0);
        chk(nmi_out, 1'b0);
        srst = 1'b0;
        $display("test reset done");
        foreach (ROWS[i])
        begin
            go(1'b0, ROWS[i].io, ROWS[i].a, BES[i % 3]);
            chk(sel.tgt, ROWS[i].t);
            chk(sel.valid, ROWS[i].t != TGT_NONE);
            if (ROWS[i].t != TGT_NONE)
                chk(sel.be, BES[i % 3]);
        end
        $display("test table done");
        go(1'b0, 1'b0, 32'he0000, 4'hf);
        chk(shadow_hit, 1'b1);
        video_shadow_en = 1'b1;
        shared_en = 1'b1;
        mezz_fitted = 1'b1;
        mezz_rom_base = 32'h0020_0000;
        mezz_rom_size = 32'h0000_1000;
        go(1'b0, 1'b0, 32'hc0000, 4'h1);
        chk(sel.tgt, TGT_DRAM);
        go(1'b0, 1'b0, 32'h0010_0000, 4'h3);
        chk(sel.tgt, TGT_SHARED);
        go(1'b0, 1'b0, 32'h0020_0ffc, 4'hf);
        chk({sel.tgt, mezz_rom_hit}, {TGT_IO_OTHER, 1'b1});
        go(1'b0, 1'b0, 32'h0020_1000, 4'hf);
        chk({sel.tgt, mezz_rom_hit}, {TGT_SHARED, 1'b0});
        go(1'b1, 1'b0, 32'h100, 4'hf);
        chk({sel.tgt, sel.vme_src}, {TGT_DRAM, 1'b1});
        wr = 1'b1;
        go(1'b0, 1'b1, 32'h278, 4'h1);
        chk({sel.valid, sel.write}, 2'b00);
        go(1'b0, 1'b1, 32'h3fa, 4'h1);
        chk({sel.write, sel.offset}, {1'b1, 32'h2});
        wr = 1'b0;
        fork
            begin
                bus_i.cyc(1'b0, '{1'b1, 1'b1, 32'h40, 4'h1, 1'b0}, ok);
                chk({ok, sel.tgt, sel.vme_src}, {1'b1, TGT_PIT, 1'b0});
            end
            begin
                bus_i.cyc(1'b1, '{1'b1, 1'b0, 32'h200, 4'hf, 1'b0}, ok2);
                chk({ok2, sel.tgt, sel.vme_src}, {1'b1, TGT_DRAM, 1'b1});
            end
        join
        $display("test options done");
        foreach (IRQS[k])
        begin
            irq_in = 16'h0001 << IRQS[k];
            repeat (3) @(posedge core_clk);
            #1;
            exp_v = VECS[k];
            chk(vector_index, exp_v);
            chk(vector_addr, {exp_v, 2'b00});
        end
        irq_in = 16'h0004;
        nmi_in = 1'b1;
        repeat (3) @(posedge core_clk);
        #1;
        chk({slave_req[1], master_req[2], nmi_out}, 3'h7);
        $display("test interrupts done");
        end_sim();
    end
endmodule : tb_pcad_decoder
`default_nettype wire
